// [occ_pkg.sv]
`default_nettype none
package occ_pkg;
  // Register offsets on the plain register port (word addresses).
  localparam logic [3:0] OFS_OSC_CONTROL  = 4'h0;
  localparam logic [3:0] OFS_CLOCK_DIVISOR = 4'h1;
  localparam logic [3:0] OFS_PLL_FEEDBACK = 4'h2;
  localparam logic [3:0] OFS_RC_TRIM      = 4'h3;
  localparam logic [3:0] OFS_AUX_CONTROL  = 4'h4;
  localparam logic [3:0] OFS_UNLOCK       = 4'h5;
  // Unlock key pair that must precede an oscillator control write.
  localparam logic [15:0] UNLOCK_KEY1     = 16'h0046;
  localparam logic [15:0] UNLOCK_KEY2     = 16'h0057;
  // Field positions in the oscillator control register.
  localparam int ACT_SRC_LSB   = 12;
  localparam int REQ_SRC_LSB   = 8;
  localparam int SW_LOCK_BIT   = 7;
  localparam int PIN_LOCK_BIT  = 6;
  localparam int PLL_LOCK_BIT  = 5;
  localparam int CLK_FAIL_BIT  = 3;
  localparam int SEC_OSC_BIT   = 1;
  localparam int SW_REQ_BIT    = 0;
  // Writable-bit masks; every other bit reads zero.
  localparam logic [15:0] MASK_CLOCK_DIVISOR = 16'hFFDF;
  localparam logic [15:0] MASK_PLL_FEEDBACK  = 16'h01FF;
  localparam logic [15:0] MASK_RC_TRIM       = 16'h003F;
  localparam logic [15:0] MASK_AUX_CONTROL   = 16'h3F80;
  // Values after power-on reset.
  localparam logic [15:0] RST_CLOCK_DIVISOR = 16'h3040;
  localparam logic [15:0] RST_PLL_FEEDBACK  = 16'h0030;
  localparam logic [15:0] RST_RC_TRIM       = 16'h0000;
  localparam logic [15:0] RST_AUX_CONTROL   = 16'h0000;
  // Source codes.
  localparam logic [2:0] SRC_FAST_INTERNAL   = 3'h0;
  localparam logic [2:0] SRC_FAST_WITH_PLL   = 3'h1;
  localparam logic [2:0] SRC_PRIMARY_PLL     = 3'h3;
  // Switch settle time in cycles after the hardware grants a switch.
  localparam int SWITCH_SETTLE_CYC = 10;
  localparam logic [1:0] MONITOR_SWITCH_ONLY = 2'h1;
endpackage : occ_pkg
`default_nettype wire

// [occ_regs.sv]
// Summary of operation
// [RL1] Read-only 3-bit active source code reflects the running oscillator.
// [RL2] Writable 3-bit requested source code names the next switch target.
// [RL3] Switch lock blocks switching; writable only when monitor config is 01.
// [RL4] Pin remap lock set makes remap register writes be ignored.
// [RL5] PLL lock status reads 1 when locked or start-up timer done.
// [RL6] Hardware sets clock fail flag on monitor failure; software only clears.
// [RL7] Secondary oscillator enable bit turns low-power oscillator on or off.
// [RL8] Software sets switch request; hardware clears it when switch completes.
// [RL9] Oscillator control writes take effect only after the unlock sequence.
// [RL10] Software must not switch directly between the two PLL sources.
// [RL11] All registers reset only on power-on reset.
// [RL12] Recover-on-interrupt makes any interrupt clear clock reduce enable.
// [RL13] Reduction field divides by two to the field value, resets to 011.
// [RL14] Clock reduce enable applies the ratio, otherwise ratio is 1:1.
// [RL15] RC postscaler at divisor bits 10-8 divides by two to the value.
// [RL16] PLL input divider at bits 4-0 divides by value plus two.
// [RL17] PLL output divider: 00 by 2, 01 by 4, 11 by 8.
// [RL18] PLL multiplier field gives value plus two, resets to 50.
// [RL19] Six-bit two's complement RC trim, about 0.375 percent per step.
// [RL20] Auxiliary reference select sits at auxiliary register bit 7.
// [RL21] Auxiliary oscillator type: 11 external, 10 crystal, 01 fast, 00 off.
// [RL22] Unimplemented bits read zero and ignore writes.
// [RL23] Auxiliary output divider: 000 by 256 down to 111 by 1.
// [RL24] Auxiliary source select routes auxiliary oscillators when set.
`timescale 1ns/10ps
`default_nettype none
module occ_regs
(
  // Clock and resets.
  input  wire logic        core_clk_i,
  input  wire logic        srst_i,
  input  wire logic        por_i,
  // Register port.
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  // Configuration and status from the clock hardware.
  input  wire logic [2:0]  por_source_i,
  input  wire logic [1:0]  monitor_config_i,
  input  wire logic        pll_locked_i,
  input  wire logic        clock_fail_i,
  input  wire logic        interrupt_i,
  // Controls to the clock hardware.
  output logic      [2:0]  active_source_code_o,
  output logic      [2:0]  requested_source_code_o,
  output logic             switch_busy_o,
  output logic             source_switch_lock_o,
  output logic             pin_remap_lock_o,
  output logic             secondary_osc_enable_o,
  output logic      [2:0]  reduce_ratio_o,
  output logic      [2:0]  rc_postscaler_o,
  output logic      [4:0]  pll_input_divider_o,
  output logic      [1:0]  pll_output_divider_o,
  output logic      [8:0]  pll_multiplier_o,
  output logic      [5:0]  rc_trim_field_o,
  output logic             aux_source_select_o,
  output logic      [1:0]  aux_osc_type_o,
  output logic      [2:0]  aux_output_divider_o,
  output logic             aux_reference_select_o
);

  logic [2:0]  act_q;
  logic [2:0]  req_q;
  logic        swlock_q;
  logic        pinlock_q;
  logic        fail_q;
  logic        secen_q;
  logic        swreq_q;
  logic [15:0] div_q;
  logic [15:0] fbd_q;
  logic [15:0] trim_q;
  logic [15:0] aux_q;
  logic [1:0]  unlock_q;
  logic [3:0]  settle_q;
  logic        rst;
  logic        osc_wr;
  logic        switch_ok;
  logic        lock_sync_q1;
  logic        lock_sync_q2;
  logic        lock_sync_q3;
  logic        lock_stat_q;
  logic        fail_sync_q1;
  logic        fail_sync_q2;
  logic        fail_sync_q3;
  logic        fail_prev_q;

  // Only power-on reset touches these registers; the system reset is ignored.
  assign rst = por_i; // see [RL11]
  assign osc_wr = wr_i && (addr_i == occ_pkg::OFS_OSC_CONTROL) && (unlock_q == 2'h2); // see [RL9]
  assign switch_ok = (monitor_config_i == occ_pkg::MONITOR_SWITCH_ONLY);

  // Unlock sequencer: two keys in a row arm one control write.
  always_ff @(posedge core_clk_i)
  begin
    if (rst)
      unlock_q <= 2'h0;
    else if (wr_i && addr_i == occ_pkg::OFS_UNLOCK)
      unlock_q <= (wdata_i == occ_pkg::UNLOCK_KEY1) ? 2'h1 :
                  (unlock_q == 2'h1 && wdata_i == occ_pkg::UNLOCK_KEY2) ? 2'h2 : 2'h0;
    else if (wr_i)
      unlock_q <= 2'h0; // see [RL9]
  end

  // The lock and fail status inputs pass three flip-flops; a change counts when the last two agree.
  always_ff @(posedge core_clk_i)
  begin
    lock_sync_q1 <= pll_locked_i;
    lock_sync_q2 <= lock_sync_q1;
    lock_sync_q3 <= lock_sync_q2;
    fail_sync_q1 <= clock_fail_i;
    fail_sync_q2 <= fail_sync_q1;
    fail_sync_q3 <= fail_sync_q2;
  end

  // Filtered status levels.
  always_ff @(posedge core_clk_i)
  begin
    if (rst)
    begin
      lock_stat_q <= 1'b0;
      fail_prev_q <= 1'b0;
    end
    else
    begin
      if (lock_sync_q2 == lock_sync_q3)
        lock_stat_q <= lock_sync_q3; // see [RL5]
      if (fail_sync_q2 == fail_sync_q3)
        fail_prev_q <= fail_sync_q3;
    end
  end

  // Oscillator control fields written by software.
  always_ff @(posedge core_clk_i)
  begin
    if (rst)
    begin
      req_q     <= 3'h0;
      swlock_q  <= 1'b0;
      pinlock_q <= 1'b0;
      secen_q   <= 1'b0;
    end
    else if (osc_wr)
    begin
      req_q     <= wdata_i[occ_pkg::REQ_SRC_LSB +: 3]; // see [RL2]
      pinlock_q <= wdata_i[occ_pkg::PIN_LOCK_BIT]; // see [RL4]
      secen_q   <= wdata_i[occ_pkg::SEC_OSC_BIT]; // see [RL7]
      if (switch_ok)
        swlock_q <= wdata_i[occ_pkg::SW_LOCK_BIT]; // see [RL3]
    end
  end

  // Clock fail flag: a new failure wins over a clearing write.
  always_ff @(posedge core_clk_i)
  begin
    if (rst)
      fail_q <= 1'b0;
    else if (fail_sync_q2 && fail_sync_q3 && !fail_prev_q)
      fail_q <= 1'b1; // see [RL6]
    else if (osc_wr && !wdata_i[occ_pkg::CLK_FAIL_BIT])
      fail_q <= 1'b0; // see [RL6]
  end

  // Switch sequence: request, settle, then load the new source.
  always_ff @(posedge core_clk_i)
  begin
    if (rst)
    begin
      act_q    <= 3'h0;
      swreq_q  <= 1'b0;
      settle_q <= 4'h0;
    end
    else if (act_q == 3'h0 && settle_q == 4'h0 && !swreq_q && !switch_ok && por_source_i != 3'h0)
    begin
      act_q <= por_source_i; // see [RL1]
    end
    else if (swreq_q)
    begin
      if (req_q == act_q)
        swreq_q <= 1'b0; // see [RL8]
      else if (settle_q == 4'(occ_pkg::SWITCH_SETTLE_CYC))
      begin
        act_q    <= req_q; // see [RL1]
        swreq_q  <= 1'b0; // see [RL8]
        settle_q <= 4'h0;
      end
      else
        settle_q <= settle_q + 4'h1;
    end
    else if (osc_wr && wdata_i[occ_pkg::SW_REQ_BIT] && switch_ok && !swlock_q)
      swreq_q <= 1'b1; // see [RL3] [RL8]
  end

  // Clock divisor register with interrupt recovery of the reduce enable.
  always_ff @(posedge core_clk_i)
  begin
    if (rst)
      div_q <= occ_pkg::RST_CLOCK_DIVISOR; // see [RL13]
    else if (wr_i && addr_i == occ_pkg::OFS_CLOCK_DIVISOR)
      div_q <= wdata_i & occ_pkg::MASK_CLOCK_DIVISOR; // see [RL22]
    else if (interrupt_i && div_q[15])
      div_q[11] <= 1'b0; // see [RL12]
  end

  // PLL feedback, RC trim and auxiliary registers.
  always_ff @(posedge core_clk_i)
  begin
    if (rst)
    begin
      fbd_q  <= occ_pkg::RST_PLL_FEEDBACK; // see [RL18]
      trim_q <= occ_pkg::RST_RC_TRIM;
      aux_q  <= occ_pkg::RST_AUX_CONTROL; // see [RL23]
    end
    else if (wr_i)
    begin
      if (addr_i == occ_pkg::OFS_PLL_FEEDBACK)
        fbd_q <= wdata_i & occ_pkg::MASK_PLL_FEEDBACK; // see [RL22]
      if (addr_i == occ_pkg::OFS_RC_TRIM)
        trim_q <= wdata_i & occ_pkg::MASK_RC_TRIM; // see [RL19]
      if (addr_i == occ_pkg::OFS_AUX_CONTROL)
        aux_q <= wdata_i & occ_pkg::MASK_AUX_CONTROL; // see [RL20]
    end
  end

  // Read data registered one cycle after the read strobe; unmapped reads zero.
  always_ff @(posedge core_clk_i)
  begin
    if (rst)
      rdata_o <= 16'h0000;
    else if (rd_i)
      unique case (addr_i)
        occ_pkg::OFS_OSC_CONTROL:
          rdata_o <= {1'b0, act_q, 1'b0, req_q, swlock_q, pinlock_q,
                      lock_stat_q, 1'b0, fail_q, 1'b0, secen_q, swreq_q}; // see [RL22]
        occ_pkg::OFS_CLOCK_DIVISOR: rdata_o <= div_q;
        occ_pkg::OFS_PLL_FEEDBACK:  rdata_o <= fbd_q;
        occ_pkg::OFS_RC_TRIM:       rdata_o <= trim_q;
        occ_pkg::OFS_AUX_CONTROL:   rdata_o <= aux_q;
        default:                    rdata_o <= 16'h0000;
      endcase
    else
      rdata_o <= 16'h0000;
  end

  // Field outputs to the clock generator.
  assign active_source_code_o    = act_q;
  assign requested_source_code_o = req_q;
  assign switch_busy_o           = swreq_q;
  assign source_switch_lock_o    = swlock_q;
  assign pin_remap_lock_o        = pinlock_q;
  assign secondary_osc_enable_o  = secen_q;
  assign reduce_ratio_o          = div_q[11] ? div_q[14:12] : 3'h0; // see [RL14]
  assign rc_postscaler_o         = div_q[10:8]; // see [RL15]
  assign pll_output_divider_o    = div_q[7:6]; // see [RL17]
  assign pll_input_divider_o     = div_q[4:0]; // see [RL16]
  assign pll_multiplier_o        = fbd_q[8:0];
  assign rc_trim_field_o         = trim_q[5:0];
  assign aux_source_select_o     = aux_q[13]; // see [RL24]
  assign aux_osc_type_o          = aux_q[12:11]; // see [RL21]
  assign aux_output_divider_o    = aux_q[10:8];
  assign aux_reference_select_o  = aux_q[7];

  // Checks.
  a_locked_write: assert property (@(posedge core_clk_i) disable iff (rst)
    (wr_i && addr_i == occ_pkg::OFS_OSC_CONTROL && unlock_q != 2'h2) |=> $stable(req_q))
    else $error("control write without unlock changed request"); // see [RL9]
  a_fail_clear: assert property (@(posedge core_clk_i) disable iff (rst)
    (!fail_q && !(fail_sync_q2 && fail_sync_q3 && !fail_prev_q)) |=> !fail_q)
    else $error("clock fail flag set by software"); // see [RL6]
  a_switch_done: assert property (@(posedge core_clk_i) disable iff (rst)
    $fell(swreq_q) |-> act_q == req_q)
    else $error("switch ended with wrong source"); // see [RL8]
  a_switch_lock: assert property (@(posedge core_clk_i) disable iff (rst)
    (swlock_q && !swreq_q) |=> !swreq_q)
    else $error("switch started while locked"); // see [RL3]
  a_reduce_ratio: assert property (@(posedge core_clk_i) disable iff (rst)
    !div_q[11] |-> reduce_ratio_o == 3'h0)
    else $error("ratio applied while reduce disabled"); // see [RL14]
  a_int_recover: assert property (@(posedge core_clk_i) disable iff (rst)
    (interrupt_i && div_q[15] && !(wr_i && addr_i == occ_pkg::OFS_CLOCK_DIVISOR)) |=> !div_q[11])
    else $error("interrupt did not clear reduce enable"); // see [RL12]
  a_reserved_zero: assert property (@(posedge core_clk_i) disable iff (rst)
    fbd_q[15:9] == 7'h00 && trim_q[15:6] == 10'h000 && aux_q[6:0] == 7'h00)
    else $error("unimplemented bits not zero"); // see [RL22]
  a_status_lock: assert property (@(posedge core_clk_i) disable iff (rst)
    (lock_sync_q2 && lock_sync_q3) |=> lock_stat_q)
    else $error("pll lock status not reported"); // see [RL5]
  a_sys_reset: assert property (@(posedge core_clk_i) disable iff (rst)
    (srst_i && !wr_i && !interrupt_i) |=> $stable(div_q))
    else $error("system reset disturbed divisor"); // see [RL11]

  // A control write after the key pair loads the requested source code.
  a_req_write: assert property (@(posedge core_clk_i) disable iff (rst)
    osc_wr |=> req_q == $past(wdata_i[occ_pkg::REQ_SRC_LSB +: 3]))
    else $error("requested source not loaded by control write"); // see [RL2]

  // The pin remap lock follows each accepted control write.
  a_pin_lock_write: assert property (@(posedge core_clk_i) disable iff (rst)
    osc_wr |=> pinlock_q == $past(wdata_i[occ_pkg::PIN_LOCK_BIT]))
    else $error("pin remap lock not loaded by control write"); // see [RL4]

  // The secondary oscillator enable follows each accepted control write.
  a_sec_enable: assert property (@(posedge core_clk_i) disable iff (rst)
    osc_wr |=> secen_q == $past(wdata_i[occ_pkg::SEC_OSC_BIT]))
    else $error("secondary enable not loaded by control write"); // see [RL7]

  // With switching enabled the active source moves only at the end of a switch.
  a_source_hold: assert property (@(posedge core_clk_i) disable iff (rst)
    (!swreq_q && switch_ok) |=> $stable(act_q))
    else $error("active source changed without a switch"); // see [RL1]

  // The switch lock cannot be cleared while the monitor setting forbids it.
  a_lock_hold: assert property (@(posedge core_clk_i) disable iff (rst)
    (swlock_q && !switch_ok) |=> swlock_q)
    else $error("switch lock changed while not writable"); // see [RL3]

  // Auxiliary register keeps only its implemented bits.
  a_aux_write: assert property (@(posedge core_clk_i) disable iff (rst)
    (wr_i && addr_i == occ_pkg::OFS_AUX_CONTROL) |=>
      aux_q == ($past(wdata_i) & occ_pkg::MASK_AUX_CONTROL))
    else $error("auxiliary register write mismatch"); // see [RL20] [RL21]

  // The selected reduction ratio is passed on while reduction is enabled.
  a_ratio_apply: assert property (@(posedge core_clk_i) disable iff (rst)
    div_q[11] |-> reduce_ratio_o == div_q[14:12])
    else $error("reduction ratio not applied"); // see [RL13] [RL14]

  // Read data stands only in the cycle after a read strobe.
  a_read_idle: assert property (@(posedge core_clk_i) disable iff (rst)
    !rd_i |=> rdata_o == 16'h0000)
    else $error("read data present without a read"); // see [RL22]

  // Any write other than a key disarms the unlock sequencer.
  a_unlock_disarm: assert property (@(posedge core_clk_i) disable iff (rst)
    (wr_i && addr_i != occ_pkg::OFS_UNLOCK) |=> unlock_q == 2'h0)
    else $error("unlock stayed armed after another write"); // see [RL9]

  // Feedback divisor keeps only its nine implemented bits.
  a_fbd_write: assert property (@(posedge core_clk_i) disable iff (rst)
    (wr_i && addr_i == occ_pkg::OFS_PLL_FEEDBACK) |=>
      fbd_q == ($past(wdata_i) & occ_pkg::MASK_PLL_FEEDBACK))
    else $error("feedback divisor write mismatch"); // see [RL18]

  // RC trim keeps only its six implemented bits.
  a_trim_write: assert property (@(posedge core_clk_i) disable iff (rst)
    (wr_i && addr_i == occ_pkg::OFS_RC_TRIM) |=>
      trim_q == ($past(wdata_i) & occ_pkg::MASK_RC_TRIM))
    else $error("rc trim write mismatch"); // see [RL19]

  // A divisor write wins over interrupt recovery in the same cycle.
  a_div_write: assert property (@(posedge core_clk_i) disable iff (rst)
    (wr_i && addr_i == occ_pkg::OFS_CLOCK_DIVISOR) |=>
      div_q == ($past(wdata_i) & occ_pkg::MASK_CLOCK_DIVISOR))
    else $error("clock divisor write mismatch"); // see [RL15] [RL16] [RL17]

  // Unimplemented control bits always read back as zero.
  a_osc_read: assert property (@(posedge core_clk_i) disable iff (rst)
    (rd_i && addr_i == occ_pkg::OFS_OSC_CONTROL) |=>
      (rdata_o[15] == 1'b0 && rdata_o[11] == 1'b0 && rdata_o[4] == 1'b0 && rdata_o[2] == 1'b0))
    else $error("unimplemented control bits not zero"); // see [RL22]

  // A filtered failure edge always sets the flag.
  a_fail_set: assert property (@(posedge core_clk_i) disable iff (rst)
    (fail_sync_q2 && fail_sync_q3 && !fail_prev_q) |=> fail_q)
    else $error("clock failure not flagged"); // see [RL6]

  // A request for the source already running ends at once.
  a_redundant_switch: assert property (@(posedge core_clk_i) disable iff (rst)
    (swreq_q && req_q == act_q) |=> !swreq_q)
    else $error("redundant switch not aborted"); // see [RL8]

  // A real switch ends when the settle count is reached.
  a_switch_settle: assert property (@(posedge core_clk_i) disable iff (rst)
    (swreq_q && settle_q == 4'(occ_pkg::SWITCH_SETTLE_CYC)) |=> !swreq_q)
    else $error("switch did not end after settling"); // see [RL8]

  // Main scenarios worth seeing at least once.
  c_switch: cover property (@(posedge core_clk_i) disable iff (rst) $fell(swreq_q));
  c_recover: cover property (@(posedge core_clk_i) disable iff (rst) interrupt_i && div_q[15] && div_q[11]);
  c_lock_status: cover property (@(posedge core_clk_i) disable iff (rst) $rose(lock_stat_q));
  c_fail: cover property (@(posedge core_clk_i) disable iff (rst) $rose(fail_q));
  c_unlock: cover property (@(posedge core_clk_i) disable iff (rst) osc_wr);
endmodule : occ_regs
`default_nettype wire

// [oscillator_control_regs_test.sv]
`timescale 1ns/10ps
`default_nettype none
// Case-equality compare of a design value with its expected value.
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin error_cnt++; $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module oscillator_control_regs_test;
  logic        core_clk_i;
  logic        srst_i;
  logic        por_i;
  logic [3:0]  addr_i;
  logic [15:0] wdata_i;
  logic        wr_i;
  logic        rd_i;
  logic [15:0] rdata_o;
  logic [2:0]  por_source_i;
  logic [1:0]  monitor_config_i;
  logic        pll_locked_i;
  logic        clock_fail_i;
  logic        interrupt_i;
  logic [2:0]  act_src;
  logic [2:0]  req_src;
  logic        sw_busy;
  logic        sw_lock;
  logic        pin_lock;
  logic        sec_en;
  logic [2:0]  ratio;
  logic [2:0]  rc_post;
  logic [4:0]  pll_in;
  logic [1:0]  pll_out;
  logic [8:0]  pll_mul;
  logic [5:0]  trim;
  logic        aux_sel;
  logic [1:0]  aux_type;
  logic [2:0]  aux_div;
  logic        aux_ref;
  logic [15:0] rd_val;
  logic [15:0] model [0:4];
  logic [15:0] mask  [0:4];
  int          error_cnt;
  int          check_count;
  int          seed;

  // Free-running core clock at 40 MHz.
  initial
  begin
    core_clk_i = 1'b0;
    forever #12.5 core_clk_i = ~core_clk_i;
  end

  occ_regs u_occ_regs (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .por_i(por_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .por_source_i(por_source_i), .monitor_config_i(monitor_config_i),
    .pll_locked_i(pll_locked_i), .clock_fail_i(clock_fail_i), .interrupt_i(interrupt_i),
    .active_source_code_o(act_src), .requested_source_code_o(req_src),
    .switch_busy_o(sw_busy), .source_switch_lock_o(sw_lock), .pin_remap_lock_o(pin_lock),
    .secondary_osc_enable_o(sec_en), .reduce_ratio_o(ratio), .rc_postscaler_o(rc_post),
    .pll_input_divider_o(pll_in), .pll_output_divider_o(pll_out),
    .pll_multiplier_o(pll_mul), .rc_trim_field_o(trim), .aux_source_select_o(aux_sel),
    .aux_osc_type_o(aux_type), .aux_output_divider_o(aux_div),
    .aux_reference_select_o(aux_ref)
  );

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  // One-cycle write strobe; the register updates on the closing edge.
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge core_clk_i);
    wr_i    <= 1'b0;
    #1;
  endtask : wr

  // One-cycle read strobe; data is taken in the single cycle after it.
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge core_clk_i);
    rd_i   <= 1'b0;
    #1;
    rd_val = rdata_o;
    `CHK(rd_val, exp)
  endtask : rd

  // Key pair first, because control writes without it are dropped.
  task automatic ulk(input logic [15:0] d);
    wr(occ_pkg::OFS_UNLOCK, occ_pkg::UNLOCK_KEY1);
    wr(occ_pkg::OFS_UNLOCK, occ_pkg::UNLOCK_KEY2);
    wr(occ_pkg::OFS_OSC_CONTROL, d);
  endtask : ulk

  // Single-cycle interrupt pulse followed by settling time.
  task automatic irq();
    @(posedge core_clk_i);
    interrupt_i <= 1'b1;
    @(posedge core_clk_i);
    interrupt_i <= 1'b0;
    repeat (2) @(posedge core_clk_i);
    #1;
  endtask : irq

  // Watchdog sized well above the expected run of about a hundred and twenty cycles.
  initial
  begin
    #(25 * 5000);
    error_cnt++;
    conclude();
  end

  // Main sequence.
  initial
  begin
    {srst_i, por_i, wr_i, rd_i, interrupt_i, clock_fail_i, pll_locked_i} = 7'h60;
    {addr_i, wdata_i} = 20'h0;
    por_source_i = 3'h4;
    monitor_config_i = occ_pkg::MONITOR_SWITCH_ONLY;
    mask = '{16'h0000, occ_pkg::MASK_CLOCK_DIVISOR, occ_pkg::MASK_PLL_FEEDBACK,
             occ_pkg::MASK_RC_TRIM, occ_pkg::MASK_AUX_CONTROL};
    model = '{16'h0000, 16'h3040, 16'h0030, 16'h0000, 16'h0000};
    error_cnt = 0;
    check_count = 0;
    seed = $urandom(64);
    repeat (4) @(posedge core_clk_i);
    srst_i <= 1'b0;
    por_i  <= 1'b0;
    for (int i = 0; i < 5; i++) rd(i[3:0], model[i]);
    rd(4'h6, 16'h0000);
    for (int i = 1; i < 5; i++)
    begin
      model[i] = 16'($urandom()) & ~16'h8800;
      wr(i[3:0], model[i]);
      model[i] = model[i] & mask[i];
      rd(i[3:0], model[i]);
    end
    `CHK({rc_post, pll_out, pll_in}, {model[1][10:6], model[1][4:0]})
    `CHK({pll_mul, trim}, {model[2][8:0], model[3][5:0]})
    `CHK({aux_sel, aux_type, aux_div, aux_ref}, model[4][13:7])
    // A system reset must leave the registers alone.
    @(posedge core_clk_i);
    srst_i <= 1'b1;
    @(posedge core_clk_i);
    srst_i <= 1'b0;
    rd(occ_pkg::OFS_CLOCK_DIVISOR, model[1]);
    wr(occ_pkg::OFS_OSC_CONTROL, 16'h0442);
    rd(occ_pkg::OFS_OSC_CONTROL, 16'h0000);
    ulk(16'h0442);
    rd(occ_pkg::OFS_OSC_CONTROL, 16'h0442);
    `CHK({req_src, pin_lock, sec_en}, 5'h13)
    // Switch request to the secondary source, cleared on completion.
    ulk(16'h0443);
    for (int n = 0; n < 40 && act_src !== 3'h4; n++) @(posedge core_clk_i);
    #1;
    rd(occ_pkg::OFS_OSC_CONTROL, 16'h4442);
    // Status inputs pass a three-flop synchroniser.
    @(posedge core_clk_i);
    clock_fail_i <= 1'b1;
    pll_locked_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    clock_fail_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    rd(occ_pkg::OFS_OSC_CONTROL, 16'h446A);
    ulk(16'h0400);
    rd(occ_pkg::OFS_OSC_CONTROL, 16'h4420);
    `CHK({pin_lock, sec_en}, 2'h0)
    // Switch lock is writable only with the monitor set to switching only.
    monitor_config_i <= 2'h3;
    ulk(16'h04A0);
    rd(occ_pkg::OFS_OSC_CONTROL, 16'h4420);
    monitor_config_i <= occ_pkg::MONITOR_SWITCH_ONLY;
    ulk(16'h0480);
    rd(occ_pkg::OFS_OSC_CONTROL, 16'h44A0);
    `CHK(sw_lock, 1'b1)
    // Reduction ratio with and without recovery on interrupt.
    wr(occ_pkg::OFS_CLOCK_DIVISOR, 16'hA800);
    `CHK(ratio, 3'h2)
    irq();
    `CHK(ratio, 3'h0)
    rd(occ_pkg::OFS_CLOCK_DIVISOR, 16'hA000);
    wr(occ_pkg::OFS_CLOCK_DIVISOR, 16'h2800);
    irq();
    `CHK(ratio, 3'h2)
    rd(occ_pkg::OFS_CLOCK_DIVISOR, 16'h2800);
    conclude();
  end
endmodule : oscillator_control_regs_test
`default_nettype wire
